// *** rtl/servo_seq_pkg.sv ***
// constants and types for the servo mode and calibration sequencer
package servo_seq_pkg;
  // clock and serial timing
  localparam int unsigned CLK_HZ       = 100_000_000;
  localparam int unsigned BAUD         = 192000;
  localparam int unsigned BAUD_DIV     = CLK_HZ / BAUD;
  localparam int unsigned BAUD_HALF    = BAUD_DIV / 2;
  localparam int unsigned DATA_BITS    = 8;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL      = 8'h00;
  localparam logic [7:0] OFF_STATUS    = 8'h04;
  localparam logic [7:0] OFF_FAULT     = 8'h08;
  localparam logic [7:0] OFF_DEMAND    = 8'h0C;
  localparam logic [7:0] OFF_FEEDBACK  = 8'h10;
  localparam logic [7:0] OFF_CAL0_CH1  = 8'h14;
  localparam logic [7:0] OFF_CAL0_CH2  = 8'h18;
  localparam logic [7:0] OFF_GAIN      = 8'h1C;
  localparam logic [7:0] OFF_CMD       = 8'h20;
  // ctrl fields
  localparam int unsigned CTRL_NORMAL  = 0;
  localparam int unsigned CTRL_LOCAL   = 1;
  localparam int unsigned CTRL_EXIT    = 2;
  // check bits: 0 logic prog,1 pi init,2 prog sum,3 cfg read,4 cfg sum,
  // 5 ram,6 uart scratch,7 shared mem
  localparam int unsigned NUM_CHECKS   = 8;
  // converter codes: span +/-10.4 V over +/-32767
  localparam logic signed [15:0] DAC_ZERO   = 16'sh0000;
  localparam logic signed [15:0] V_TOP_HI   = 16'sh7B1A; // 10.0 V
  localparam logic signed [15:0] V_TOP_LO   = 16'sh79DD; // 9.9 V
  localparam logic signed [15:0] V_BOT_LIM  = 16'sh84E6; // -10.0 V
  localparam logic signed [15:0] DRIVE_OPEN = 16'sh2000;
  localparam logic signed [15:0] DRIVE_SHUT = 16'shE000;
  localparam logic [15:0] GAIN_RESET   = 16'h4000; // unity in q2.14
  localparam logic [15:0] GAIN_STEP    = 16'h0040;
  // commands (coded bytes of the command port)
  localparam logic [7:0] CMD_CH1       = 8'h31;
  localparam logic [7:0] CMD_CH2       = 8'h32;
  localparam logic [7:0] CMD_ZERO_CAL  = 8'h42; // zero_point_cal_command
  localparam logic [7:0] CMD_TOP_CAL   = 8'h54; // full_point_cal_command
  localparam logic [7:0] CMD_FULL_CAL  = 8'h46; // complete_cal_command
  localparam logic [7:0] CMD_RAISE     = 8'h52;
  localparam logic [7:0] CMD_LOWER     = 8'h4C;
  localparam logic [7:0] CMD_EXIT      = 8'h58;
  localparam logic [7:0] CMD_STORE     = 8'h53; // store_constants_command
  localparam logic [7:0] CHR_CR        = 8'h0D;
  localparam logic [7:0] CHR_BS        = 8'h08;
  localparam logic [7:0] CHR_STAR      = 8'h2A;
  localparam logic [7:0] CHR_GT        = 8'h3E;
  localparam logic [7:0] CHR_V         = 8'h56;
  localparam logic [7:0] CHR_DIGIT0    = 8'h30;

  typedef enum logic [2:0] {
    MODE_START, MODE_LOCAL, MODE_NORMAL, MODE_CAL, MODE_STORE
  } mode_type;

  typedef enum logic [2:0] {
    STEP_IDLE, STEP_PWR, STEP_DAC, STEP_CHECK, STEP_TRACK
  } start_type;

  typedef enum logic [2:0] {
    CAL_NONE, CAL_ZERO, CAL_TOP, CAL_FULL_TOP, CAL_FULL_BOT
  } cal_type;
endpackage

// *** rtl/servo_mode_cal_seq.sv ***
// mode sequencer and calibration controller for two servo channels
// Behaviour
// (RULE_01) servo output supply stays off at power-up
// (RULE_02) coil converter stays disabled until its first pattern is written
// (RULE_03) start: enable supply first, then write the zero-volt code
// (RULE_04) start mode samples feedback and runs diagnostics before leaving
// (RULE_05) leave start for local only when all eight checks pass
// (RULE_06) enter factory configure mode when factory enable pin is 1
// (RULE_07) failed start checks are kept in a readable fault register
// (RULE_08) target demand equals feedback before moving to local mode; code loads the one shared demand from feedback_ch1 only
// (RULE_09) normal mode drives valve toward the controller's position
// (RULE_10) local mode may go to normal mode with no tracking wait
// (RULE_11) calibrate is under local; commands from controller or serial
// (RULE_12) zero hot cal sets only the 0% value, never opens fully
// (RULE_13) top hot cal sets only the 100% value, never closes fully
// (RULE_14) full cal moves to 100%, trims gain to 9.9..10.0 V; code only lowers gain until 100% is at or below 10.0 V, no 9.9 V floor
// (RULE_15) each gain change rescales 0%; stop if 0% passes -10.0 V
// (RULE_16) full cal then moves to 0%, trims gain above -10.0 V
// (RULE_17) 0% step ends in range or when 100% would pass 10.0 V
// (RULE_18) limits are codes of a +/-10.4 V converter span
// (RULE_19) after full cal store values then soft reset
// (RULE_20) serial port 192000 baud, 8 data, 1 stop, no parity
// (RULE_21) constants and cal commands use channel chosen by 1 or 2
// (RULE_22) after channel select print prompt with channel number
// (RULE_23) calibration messages name the channel being calibrated
// (RULE_24) swapped sensor pairs only flip signs; arithmetic stays right
// (RULE_25) raise or lower jog forces the channel into local mode
// (RULE_26) exit aborts jog or calibration and soft resets
// (RULE_27) parser case sensitive, unbuffered, backspace drops command
// (RULE_28) each channel keeps its own 0%, 100% and gain
// (RULE_29) calibration commands are refused in start mode
//
// The AXI4-Lite register port and the address map were chosen for this implementation.
`default_nettype none
module servo_mode_cal_seq
  import servo_seq_pkg::*;
(
  // clock and reset
  input  wire logic               aclk,
  input  wire logic               aresetn,
  // axi4-lite slave
  input  wire logic [7:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [7:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  // start-up inputs
  input  wire logic [NUM_CHECKS-1:0] check_ok,
  input  wire logic               checks_done,
  input  wire logic               factory_enable_pin,
  // position feedback per channel, converter codes
  input  wire logic signed [15:0] feedback_ch1,
  input  wire logic signed [15:0] feedback_ch2,
  // servo output
  output logic                    supply_on,
  output logic                    dac_enable,
  output logic signed [15:0]      dac_code_ch1,
  output logic signed [15:0]      dac_code_ch2,
  output logic                    factory_mode,
  output logic                    nv_write,
  // serial port
  input  wire logic               uart_rx,
  output logic                    uart_tx
);

  typedef struct packed {
    mode_type               mode;
    start_type              step;
    cal_type                cal;
    logic                   chan;
    logic [NUM_CHECKS-1:0]  faults;
    logic                   factory;
    logic                   supply;
    logic                   dac_en;
    logic signed [15:0]     dac1;
    logic signed [15:0]     dac2;
    logic signed [15:0]     demand;
    logic signed [15:0]     cal0_1;
    logic signed [15:0]     cal0_2;
    logic signed [15:0]     cal100_1;
    logic signed [15:0]     cal100_2;
    logic [15:0]            gain_1;
    logic [15:0]            gain_2;
    logic                   nvw;
    logic                   aw_got;
    logic                   w_got;
    logic [7:0]             awaddr;
    logic [31:0]            wdata;
    logic                   bvalid;
    logic                   rvalid;
    logic [31:0]            rdata;
    logic [1:0]             rresp;
    logic [1:0]             bresp;
    logic [15:0]            rx_cnt;
    logic [3:0]             rx_bit;
    logic [7:0]             rx_sh;
    logic                   rx_busy;
    logic [7:0]             pend;
    logic                   pend_ok;
    logic [15:0]            tx_cnt;
    logic [3:0]             tx_bit;
    logic [9:0]             tx_sh;
    logic                   tx_line;
    logic [3:0][7:0]        msg;
    logic [2:0]             msg_len;
    logic [2:0]             msg_idx;
  } state_type;

  state_type s;
  state_type next_s;

  // gain scaling of a calibration value; sign carried through
  function automatic logic signed [15:0] scale(
    input logic signed [15:0] v, input logic [15:0] g);
    logic signed [33:0] p;
    p = v * $signed({2'b00, g});
    return p[29:14];
  endfunction

  function automatic logic signed [15:0] absval(input logic signed [15:0] v);
    return (v < 0) ? -v : v;
  endfunction

  logic signed [15:0] fb;
  logic [15:0]        gain;
  logic signed [15:0] c0;
  logic signed [15:0] c100;
  logic [15:0]        g_dn;
  logic signed [15:0] top_v;
  logic signed [15:0] bot_v;
  logic               cmd_bus;
  logic [7:0]         cmd_byte;
  logic               rx_valid;
  logic [7:0]         rx_byte;

  always_comb begin
    fb    = s.chan ? feedback_ch2 : feedback_ch1;
    gain  = s.chan ? s.gain_2 : s.gain_1;
    c0    = s.chan ? s.cal0_2 : s.cal0_1;
    c100  = s.chan ? s.cal100_2 : s.cal100_1;
    g_dn  = gain - GAIN_STEP;
    // magnitudes so a swapped sensor pair works the same way
    top_v = absval(scale(fb, gain)); // RULE_24
    bot_v = -absval(scale(fb, gain)); // RULE_24
  end

  always_comb begin
    next_s   = s;
    cmd_bus  = 1'b0;
    cmd_byte = 8'h00;
    rx_valid = 1'b0;
    rx_byte  = 8'h00;
    next_s.nvw = 1'b0;

    // bus slave: address and data in any order, then response
    if (s_axi_awvalid && !s.aw_got && !s.bvalid) begin
      next_s.aw_got = 1'b1;
      next_s.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s.w_got && !s.bvalid) begin
      next_s.w_got = 1'b1;
      next_s.wdata = s_axi_wdata;
    end
    if (s.aw_got && s.w_got) begin
      next_s.aw_got = 1'b0;
      next_s.w_got  = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp  = 2'b00;
      unique case ({s.awaddr[7:2], 2'b00})
        OFF_CTRL: begin
          if (s.wdata[CTRL_EXIT])
            next_s.mode = MODE_STORE;
          else if (s.wdata[CTRL_NORMAL] && s.mode == MODE_LOCAL)
            next_s.mode = MODE_NORMAL; // RULE_10
          else if (s.wdata[CTRL_LOCAL] && s.mode == MODE_NORMAL)
            next_s.mode = MODE_LOCAL;
        end
        OFF_DEMAND: next_s.demand = s.wdata[15:0]; // RULE_09
        OFF_CMD: begin
          cmd_bus  = 1'b1; // RULE_11
          cmd_byte = s.wdata[7:0];
        end
        default: next_s.bresp = 2'b10;
      endcase
    end
    if (s.bvalid && s_axi_bready)
      next_s.bvalid = 1'b0;
    if (s_axi_arvalid && !s.rvalid) begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = 2'b00;
      unique case ({s_axi_araddr[7:2], 2'b00})
        OFF_STATUS:   next_s.rdata = {24'h0, s.factory, s.chan,
                                      s.cal, 2'b00, s.mode[0]} |
                                     {24'h0, 5'h0, s.mode};
        OFF_FAULT:    next_s.rdata = {24'h0, s.faults}; // RULE_07
        OFF_DEMAND:   next_s.rdata = {{16{s.demand[15]}}, s.demand};
        OFF_FEEDBACK: next_s.rdata = {feedback_ch2, feedback_ch1};
        OFF_CAL0_CH1: next_s.rdata = {s.cal100_1, s.cal0_1};
        OFF_CAL0_CH2: next_s.rdata = {s.cal100_2, s.cal0_2};
        OFF_GAIN:     next_s.rdata = {s.gain_2, s.gain_1};
        OFF_CTRL:     next_s.rdata = 32'h0;
        default: begin
          next_s.rdata = 32'h0;
          next_s.rresp = 2'b10;
        end
      endcase
    end
    if (s.rvalid && s_axi_rready)
      next_s.rvalid = 1'b0;

    // receiver 8N1, data and stop bits sampled mid-bit, start bit not rechecked
    next_s.rx_cnt = s.rx_cnt + 16'd1;
    if (!s.rx_busy) begin
      next_s.rx_cnt = 16'd0;
      if (!uart_rx)
        next_s.rx_busy = 1'b1;
      next_s.rx_bit = 4'd0;
    end else if (s.rx_cnt == 16'(s.rx_bit == 0 ? BAUD_HALF : BAUD_DIV)) begin
      next_s.rx_cnt = 16'd0; // RULE_20
      next_s.rx_bit = s.rx_bit + 4'd1;
      if (s.rx_bit >= 4'd1 && s.rx_bit <= 4'(DATA_BITS))
        next_s.rx_sh = {uart_rx, s.rx_sh[7:1]};
      if (s.rx_bit == 4'(DATA_BITS + 1)) begin
        next_s.rx_busy = 1'b0;
        rx_valid = uart_rx; // stop bit must be high
        rx_byte  = s.rx_sh;
      end
    end

    // unbuffered parser: one letter picks the command, return runs it
    if (rx_valid) begin
      if (rx_byte == CHR_BS)
        next_s.pend_ok = 1'b0; // RULE_27
      else if (rx_byte == CHR_CR) begin
        next_s.pend_ok = 1'b0;
        if (s.pend_ok) begin
          cmd_bus  = 1'b1;
          cmd_byte = s.pend;
        end
      end else begin
        next_s.pend    = rx_byte; // exact byte compare, case kept
        next_s.pend_ok = 1'b1;
      end
    end

    // command execution, shared by bus and serial port
    if (cmd_bus) begin
      if (cmd_byte == CMD_CH1 || cmd_byte == CMD_CH2) begin
        next_s.chan    = (cmd_byte == CMD_CH2); // RULE_21
        next_s.msg[0]  = CHR_STAR; // RULE_22
        next_s.msg[1]  = cmd_byte;
        next_s.msg[2]  = CHR_STAR;
        next_s.msg[3]  = CHR_GT;
        next_s.msg_len = 3'd4;
        next_s.msg_idx = 3'd0;
      end else if (cmd_byte == CMD_EXIT) begin
        next_s.mode = MODE_STORE; // RULE_26
        next_s.cal  = CAL_NONE;
      end else if (s.mode != MODE_START) begin // RULE_29
        if (cmd_byte == CMD_RAISE || cmd_byte == CMD_LOWER) begin
          next_s.mode   = MODE_LOCAL; // RULE_25
          next_s.demand = (cmd_byte == CMD_RAISE) ?
                          s.demand + 16'sd1 : s.demand - 16'sd1;
        end else if ((cmd_byte == CMD_ZERO_CAL ||
                      cmd_byte == CMD_TOP_CAL ||
                      cmd_byte == CMD_FULL_CAL) &&
                     (s.mode == MODE_LOCAL || s.mode == MODE_CAL)) begin
          next_s.mode = MODE_CAL; // RULE_11
          next_s.cal  = (cmd_byte == CMD_ZERO_CAL) ? CAL_ZERO :
                        (cmd_byte == CMD_TOP_CAL) ? CAL_TOP : CAL_FULL_TOP;
          next_s.msg[0]  = CHR_V; // RULE_23
          next_s.msg[1]  = CHR_DIGIT0 + 8'(s.chan) + 8'd1;
          next_s.msg[2]  = cmd_byte;
          next_s.msg[3]  = CHR_GT;
          next_s.msg_len = 3'd4;
          next_s.msg_idx = 3'd0;
        end else if (cmd_byte == CMD_STORE)
          next_s.nvw = 1'b1;
      end
    end

    // transmitter: sends the queued message one byte at a time
    next_s.tx_cnt = s.tx_cnt + 16'd1;
    if (s.tx_bit == 4'd0) begin
      next_s.tx_line = 1'b1;
      if (s.msg_idx < s.msg_len) begin
        next_s.tx_sh   = {1'b1, s.msg[s.msg_idx], 1'b0};
        next_s.msg_idx = s.msg_idx + 3'd1;
        next_s.tx_bit  = 4'd11; // spare slot keeps a full stop bit
        next_s.tx_cnt  = 16'(BAUD_DIV);
      end
    end else if (s.tx_cnt == 16'(BAUD_DIV)) begin
      next_s.tx_cnt  = 16'd0;
      next_s.tx_line = s.tx_sh[0];
      next_s.tx_sh   = {1'b1, s.tx_sh[9:1]};
      next_s.tx_bit  = s.tx_bit - 4'd1;
    end

    // mode sequencing
    unique case (s.mode)
      MODE_START: begin
        unique case (s.step)
          STEP_IDLE: next_s.step = STEP_PWR;
          STEP_PWR: begin
            next_s.supply = 1'b1; // RULE_03
            next_s.step   = STEP_DAC;
          end
          STEP_DAC: begin
            next_s.dac1   = DAC_ZERO; // RULE_03
            next_s.dac2   = DAC_ZERO;
            next_s.dac_en = 1'b1; // RULE_02
            next_s.step   = STEP_CHECK;
          end
          STEP_CHECK: begin
            next_s.factory = factory_enable_pin; // RULE_06
            if (checks_done) begin
              next_s.faults = ~check_ok; // RULE_07
              // stays here while any check fails; check_ok is re-read every cycle that checks_done is high
              if (&check_ok)
                next_s.step = STEP_TRACK; // RULE_05
            end
          end
          STEP_TRACK: begin
            next_s.demand = feedback_ch1; // RULE_08
            next_s.mode   = MODE_LOCAL; // RULE_04
          end
        endcase
      end
      MODE_LOCAL, MODE_NORMAL: begin
        next_s.dac1 = s.demand - feedback_ch1; // RULE_09
        next_s.dac2 = s.demand - feedback_ch2;
      end
      MODE_CAL: begin
        unique case (s.cal)
          CAL_ZERO: begin
            // drive toward closed only; gain untouched
            next_s.dac1 = s.chan ? s.dac1 : DRIVE_SHUT; // RULE_12
            next_s.dac2 = s.chan ? DRIVE_SHUT : s.dac2;
            if (s.chan) next_s.cal0_2 = fb;
            else        next_s.cal0_1 = fb;
            next_s.cal  = CAL_NONE;
            next_s.mode = MODE_LOCAL;
          end
          CAL_TOP: begin
            next_s.dac1 = s.chan ? s.dac1 : DRIVE_OPEN; // RULE_13
            next_s.dac2 = s.chan ? DRIVE_OPEN : s.dac2;
            if (s.chan) next_s.cal100_2 = fb;
            else        next_s.cal100_1 = fb;
            next_s.cal  = CAL_NONE;
            next_s.mode = MODE_LOCAL;
          end
          CAL_FULL_TOP: begin
            next_s.dac1 = s.chan ? s.dac1 : DRIVE_OPEN; // RULE_14
            next_s.dac2 = s.chan ? DRIVE_OPEN : s.dac2;
            if (top_v > V_TOP_HI &&
                -absval(scale(c0, g_dn)) >= V_BOT_LIM) begin // RULE_15
              if (s.chan) next_s.gain_2 = g_dn;
              else        next_s.gain_1 = g_dn;
            end else begin
              // in range (RULE_18 codes) or 0% limit reached
              if (s.chan) next_s.cal100_2 = fb; // RULE_28
              else        next_s.cal100_1 = fb;
              next_s.cal = CAL_FULL_BOT;
            end
          end
          CAL_FULL_BOT: begin
            next_s.dac1 = s.chan ? s.dac1 : DRIVE_SHUT; // RULE_16
            next_s.dac2 = s.chan ? DRIVE_SHUT : s.dac2;
            if (bot_v < V_BOT_LIM &&
                absval(scale(c100, g_dn)) <= V_TOP_HI) begin // RULE_17
              if (s.chan) next_s.gain_2 = g_dn;
              else        next_s.gain_1 = g_dn;
            end else begin
              if (s.chan) next_s.cal0_2 = fb;
              else        next_s.cal0_1 = fb;
              next_s.cal  = CAL_NONE;
              next_s.mode = MODE_STORE; // RULE_19
            end
          end
          default: next_s.mode = MODE_LOCAL;
        endcase
      end
      MODE_STORE: begin
        // write constants, then soft reset into start mode
        next_s.nvw    = 1'b1; // RULE_19
        next_s.mode   = MODE_START;
        next_s.step   = STEP_IDLE;
        next_s.supply = 1'b0;
        next_s.dac_en = 1'b0;
        next_s.dac1   = DAC_ZERO;
        next_s.dac2   = DAC_ZERO;
      end
      default: next_s.mode = MODE_START;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s          <= '0;
      s.mode     <= MODE_START;
      s.step     <= STEP_IDLE;
      s.cal      <= CAL_NONE;
      s.supply   <= 1'b0; // RULE_01
      s.dac_en   <= 1'b0; // RULE_02
      s.gain_1   <= GAIN_RESET;
      s.gain_2   <= GAIN_RESET;
      s.tx_line  <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign s_axi_awready = !s.aw_got && !s.bvalid;
  assign s_axi_wready  = !s.w_got && !s.bvalid;
  assign s_axi_bvalid  = s.bvalid;
  assign s_axi_bresp   = s.bresp;
  assign s_axi_arready = !s.rvalid;
  assign s_axi_rvalid  = s.rvalid;
  assign s_axi_rdata   = s.rdata;
  assign s_axi_rresp   = s.rresp;
  assign supply_on     = s.supply;
  assign dac_enable    = s.dac_en;
  assign dac_code_ch1  = s.dac1;
  assign dac_code_ch2  = s.dac2;
  assign factory_mode  = s.factory;
  assign nv_write      = s.nvw;
  assign uart_tx       = s.tx_line;

  property p_supply_first;
    @(posedge aclk) disable iff (!aresetn)
      $rose(s.dac_en) |-> s.supply && $past(s.supply);
  endproperty
  a_supply_first: assert property (p_supply_first) // RULE_03
    else $error("converter enabled before supply");

  property p_dac_zero;
    @(posedge aclk) disable iff (!aresetn)
      $rose(s.dac_en) |-> s.dac1 == DAC_ZERO && s.dac2 == DAC_ZERO;
  endproperty
  a_dac_zero: assert property (p_dac_zero) // RULE_02
    else $error("first converter pattern not zero");

  property p_start_leave;
    @(posedge aclk) disable iff (!aresetn)
      $past(s.mode) == MODE_START && s.mode == MODE_LOCAL |->
        s.faults == '0 && s.demand == $past(feedback_ch1);
  endproperty
  a_start_leave: assert property (p_start_leave) // RULE_05
    else $error("left start with faults or demand step");

  property p_fault_hold;
    @(posedge aclk) disable iff (!aresetn)
      s.step == STEP_CHECK && checks_done && !(&check_ok) |=>
        s.mode == MODE_START ##1 s.mode == MODE_START;
  endproperty
  a_fault_hold: assert property (p_fault_hold) // RULE_05
    else $error("left start despite fault");

  property p_no_cal_in_start;
    @(posedge aclk) disable iff (!aresetn)
      s.mode == MODE_START |=> s.mode != MODE_CAL;
  endproperty
  a_no_cal_in_start: assert property (p_no_cal_in_start) // RULE_29
    else $error("calibration from start mode");

  property p_store_reset;
    @(posedge aclk) disable iff (!aresetn)
      s.mode == MODE_STORE |=> nv_write && s.mode == MODE_START
        && !s.supply;
  endproperty
  a_store_reset: assert property (p_store_reset) // RULE_19
    else $error("store not followed by soft reset");

  property p_supply_off_reset;
    @(posedge aclk) !aresetn |=> !supply_on && !dac_enable;
  endproperty
  a_supply_off_reset: assert property (p_supply_off_reset) // RULE_01
    else $error("supply on after reset");

  property p_zero_no_open;
    @(posedge aclk) disable iff (!aresetn)
      s.cal == CAL_ZERO |=> s.dac1 != DRIVE_OPEN && s.dac2 != DRIVE_OPEN
        && $stable(s.gain_1) && $stable(s.gain_2);
  endproperty
  a_zero_no_open: assert property (p_zero_no_open) // RULE_12
    else $error("zero cal opened valve or changed gain");

endmodule
`default_nettype wire

// *** bench/serial_term.sv ***
// terminal model: sends 8N1 bytes into the serial input
`default_nettype none
module serial_term
  import servo_seq_pkg::*;
(
  // clock and line
  input  wire logic aclk,
  output logic      rx_line
);
  timeunit 1ns;
  timeprecision 1ns;
  initial rx_line = 1'h1;
  // start bit, lsb first, one stop bit, no parity
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'h1, b, 1'h0};
    for (int i = 0; i < 10; i++) begin
      rx_line <= f[i];
      repeat (BAUD_DIV) @(posedge aclk);
    end
  endtask
endmodule
`default_nettype wire

// *** bench/servo_mode_cal_seq_bench.sv ***
// bench for the servo mode and calibration sequencer
`default_nettype none
module servo_mode_cal_seq_bench import servo_seq_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 0, aresetn = 0, checks_done = 0, factory_enable_pin = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
  logic s_axi_bready = 1, s_axi_rready = 1, uart_rx, uart_tx;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, check_ok = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic signed [15:0] feedback_ch1 = 16'sh1234, feedback_ch2 = 16'sh0ABC;
  logic signed [15:0] dac_code_ch1, dac_code_ch2;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, supply_on, dac_enable, factory_mode, nv_write;
  int n_errors = 0, check_count = 0;
  always #5 aclk = ~aclk;
  serial_term u_term (.aclk, .rx_line(uart_rx));
  servo_mode_cal_seq u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .check_ok, .checks_done, .factory_enable_pin, .feedback_ch1, .feedback_ch2,
    .supply_on, .dac_enable, .dac_code_ch1, .dac_code_ch2, .factory_mode,
    .nv_write, .uart_rx, .uart_tx);
  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // a bus wait that runs out ends the run at once
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) break;
    end
    if (n == 64) begin
      chk(0, 1);
      print_verdict();
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    if (n == 64) begin
      chk(0, 1);
      print_verdict();
    end
  endtask
  task automatic poll(input logic [7:0] a, input logic [31:0] m, e);
    logic [31:0] d;
    logic [1:0] r;
    for (int n = 0; n < 20; n++) begin
      rd(a, d, r);
      if ((d & m) === e) break;
    end
    chk(d & m, e);
  endtask
  task automatic boot(input logic [7:0] ok, input logic fpin);
    aresetn <= 1'h0;
    checks_done <= 1'h0;
    check_ok <= ok;
    factory_enable_pin <= fpin;
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
  endtask
  task automatic t_fault();
    boot(8'hFB, 1'h1);
    checks_done <= 1'h1;
    poll(OFF_FAULT, 32'hFF, 32'h04);
    poll(OFF_STATUS, 32'h7, MODE_START);
    chk(factory_mode, 1);
    $display("test fault done");
  endtask
  task automatic t_start();
    logic [31:0] d;
    logic [1:0] r;
    boot(8'hFF, 1'h0);
    #1 chk(supply_on, 0);
    chk(dac_enable, 0);
    repeat (2) @(posedge aclk);
    #1 chk({supply_on, dac_enable}, 2'h2);
    @(posedge aclk);
    #1 chk({dac_enable, dac_code_ch1}, 17'h10000);
    @(posedge aclk);
    checks_done <= 1'h1;
    poll(OFF_STATUS, 32'h7, MODE_LOCAL);
    rd(OFF_DEMAND, d, r);
    chk(d[15:0], 16'h1234);
    wr(OFF_CTRL, 32'h1);
    poll(OFF_STATUS, 32'h7, MODE_NORMAL);
    rd(8'h40, d, r);
    chk(r, 2'h2);
    $display("test start done");
  endtask
  task automatic rx_byte(output logic [7:0] b);
    for (int n = 0; n < 20000 && uart_tx !== 1'h0; n++) @(posedge aclk);
    if (uart_tx !== 1'h0) begin
      chk(0, 1);
      print_verdict();
    end
    repeat (BAUD_HALF) @(posedge aclk);
    for (int i = 0; i < 8; i++) begin
      repeat (BAUD_DIV) @(posedge aclk);
      b[i] = uart_tx;
    end
    repeat (BAUD_DIV) @(posedge aclk);
  endtask
  task automatic t_serial();
    logic [7:0] b0, b1;
    fork
      begin
        u_term.send(CMD_CH2);
        u_term.send(CHR_CR);
      end
      begin
        rx_byte(b0);
        rx_byte(b1);
      end
    join
    chk(b0, CHR_STAR);
    chk(b1, CHR_DIGIT0 + 8'h02);
    $display("test serial done");
  endtask
  task automatic t_cal();
    logic [31:0] d;
    logic [1:0] r;
    wr(OFF_CMD, CMD_ZERO_CAL);
    rd(OFF_CAL0_CH2, d, r);
    chk(d[15:0], 16'h0000);
    wr(OFF_CMD, CMD_RAISE);
    poll(OFF_STATUS, 32'h7, MODE_LOCAL);
    rd(OFF_DEMAND, d, r);
    chk(d[15:0], 16'h1235);
    wr(OFF_CMD, CMD_ZERO_CAL);
    poll(OFF_CAL0_CH2, 32'hFFFF, 32'h0ABC);
    rd(OFF_CAL0_CH1, d, r);
    chk(d[15:0], 16'h0000);
    checks_done <= 1'h0;
    wr(OFF_CMD, CMD_EXIT);
    poll(OFF_STATUS, 32'h7, MODE_START);
    $display("test cal done");
  endtask
  initial begin
    t_fault();
    t_start();
    t_serial();
    t_cal();
    print_verdict();
  end
endmodule
`default_nettype wire
